// [usb_host_periodic_and_root_hub_config.v]
// The APB interface to the registers is this design's own decision.
`include "usb_periodic_defs.vh"

module usb_host_periodic_and_root_hub_config (
    input wire ref_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire operational,
    input wire xact_busy,
    input wire ls_request,
    output reg [13:0] frame_bits_left,
    output reg periodic_priority,
    output reg ls_start_ok,
    output reg ls_start,
    output reg [1:0] power_mode,
    output reg [1:0] overcurrent_mode
);

    // ---------------------------------------------------------
    // register storage
    // ---------------------------------------------------------
    reg [13:0] periodic_begin_value;
    reg [11:0] slow_packet_margin_value;
    reg [7:0] port_power_settle_time;
    reg overcurrent_absent;
    reg overcurrent_per_port_select;
    reg power_always_on;
    reg power_switch_granularity;
    reg [7:0] downstream_port_count;
    reg [13:0] frame_interval;
    reg periodic_pending;
    reg [31:0] next_prdata;
    reg next_slverr;

    // reset image of the first descriptor, split into its fields below
    localparam [31:0] RH_RESET = `RST_RH_DESC_FIRST;

    wire [13:0] count_now;
    wire bit_tick;
    wire frame_start;
    wire setup_phase;
    wire access_write;
    wire full_word;
    wire [31:0] rh_first_word;

    // ---------------------------------------------------------
    // helpers
    // ---------------------------------------------------------
    // true when the offset is one of ours
    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `OFF_PERIODIC_BEGIN) ||
                     (a == `OFF_SLOW_MARGIN) ||
                     (a == `OFF_RH_DESC_FIRST) ||
                     (a == `OFF_FRAME_INTERVAL) ||
                     (a == `OFF_SCHED_STATUS);
        end
    endfunction

    // low-speed packet may only begin while the countdown covers the margin
    function margin_fits;
        input [13:0] left;
        input [11:0] margin;
        begin
            margin_fits = (left >= {2'h0, margin});
        end
    endfunction

    // 2-bit mode code from an off bit and a select bit
    function [1:0] mode_code;
        input off_bit;
        input sel_bit;
        begin
            if (off_bit)
                mode_code = 2'h2;
            else if (sel_bit)
                mode_code = 2'h1;
            else
                mode_code = 2'h0;
        end
    endfunction

    // ---------------------------------------------------------
    // frame countdown
    // ---------------------------------------------------------
    frame_countdown u_count (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .run(operational),
        .frame_interval(frame_interval),
        .frame_bits_left(count_now),
        .bit_tick(bit_tick),
        .frame_start(frame_start)
    );

    // ---------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------
    assign setup_phase = psel && !penable;
    assign access_write = psel && penable && pready && pwrite;
    assign full_word = (pstrb == 4'hf);

    // compound flag is forced zero in the read image
    assign rh_first_word = {port_power_settle_time, 11'h000,
                            overcurrent_absent,
                            overcurrent_per_port_select,
                            1'b0,
                            power_always_on,
                            power_switch_granularity,
                            downstream_port_count};

    // read mux and error check, evaluated in the setup cycle
    always @* begin
        next_prdata = 32'h00000000;
        next_slverr = 1'b0;
        if (!mapped(paddr)) begin
            next_slverr = 1'b1;
        end else if (pwrite && !full_word &&
                     paddr == `OFF_RH_DESC_FIRST) begin
            next_slverr = 1'b1;
        end
        case (paddr)
            `OFF_PERIODIC_BEGIN:
                next_prdata = {18'h00000, periodic_begin_value};
            `OFF_SLOW_MARGIN:
                next_prdata = {20'h00000, slow_packet_margin_value};
            `OFF_RH_DESC_FIRST:
                next_prdata = rh_first_word;
            `OFF_FRAME_INTERVAL:
                next_prdata = {18'h00000, frame_interval};
            `OFF_SCHED_STATUS:
                next_prdata = {14'h0000, periodic_priority,
                               ls_start_ok, 2'h0, count_now};
            default:
                next_prdata = 32'h00000000;
        endcase
    end

    // no wait state: answer lands in the first access cycle
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= next_slverr;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // ---------------------------------------------------------
    // register writes
    // ---------------------------------------------------------
    // descriptor writes do not look at operational state
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            periodic_begin_value <= `RST_PERIODIC_BEGIN;
            slow_packet_margin_value <= `RST_SLOW_MARGIN;
            port_power_settle_time <=
                RH_RESET[`RH_SETTLE_HI:`RH_SETTLE_LO];
            overcurrent_absent <= RH_RESET[`RH_OC_ABSENT];
            overcurrent_per_port_select <= RH_RESET[`RH_OC_PER_PORT];
            power_always_on <= RH_RESET[`RH_ALWAYS_ON];
            power_switch_granularity <= RH_RESET[`RH_GRANULARITY];
            downstream_port_count <=
                RH_RESET[`RH_PORTS_HI:`RH_PORTS_LO];
            frame_interval <= `RST_FRAME_INTERVAL;
        end else if (access_write && !pslverr) begin
            case (paddr)
                `OFF_PERIODIC_BEGIN:
                    periodic_begin_value <= pwdata[13:0];
                `OFF_SLOW_MARGIN:
                    slow_packet_margin_value <= pwdata[11:0];
                `OFF_RH_DESC_FIRST: begin
                    port_power_settle_time <=
                        pwdata[`RH_SETTLE_HI:`RH_SETTLE_LO];
                    overcurrent_absent <= pwdata[`RH_OC_ABSENT];
                    overcurrent_per_port_select <=
                        pwdata[`RH_OC_PER_PORT];
                    power_always_on <= pwdata[`RH_ALWAYS_ON];
                    power_switch_granularity <=
                        pwdata[`RH_GRANULARITY];
                end
                `OFF_FRAME_INTERVAL:
                    frame_interval <= pwdata[13:0];
                default: begin
                end
            endcase
        end
    end

    // ---------------------------------------------------------
    // scheduling decisions
    // ---------------------------------------------------------
    // the threshold is noticed on a bit tick but only takes effect
    // once the running control or bulk transaction has finished
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            periodic_pending <= 1'b0;
            periodic_priority <= 1'b0;
        end else if (!operational || frame_start) begin
            periodic_pending <= 1'b0;
            periodic_priority <= 1'b0;
        end else begin
            if (bit_tick && count_now <= periodic_begin_value)
                periodic_pending <= 1'b1;
            if ((periodic_pending || count_now <= periodic_begin_value)
                && !xact_busy)
                periodic_priority <= 1'b1;
        end
    end

    // low-speed gate, and a start raised every cycle that a request can be granted
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ls_start_ok <= 1'b0;
            ls_start <= 1'b0;
        end else begin
            ls_start_ok <= operational &&
                margin_fits(count_now, slow_packet_margin_value);
            ls_start <= operational && ls_request && !xact_busy &&
                margin_fits(count_now, slow_packet_margin_value);
        end
    end

    // ---------------------------------------------------------
    // mirrored outputs
    // ---------------------------------------------------------
    // power: 2 always on, 1 per port, 0 all ports together
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_bits_left <= 14'h0000;
            power_mode <= 2'h0;
            overcurrent_mode <= 2'h0;
        end else begin
            frame_bits_left <= count_now;
            power_mode <= mode_code(power_always_on,
                                    power_switch_granularity);
            overcurrent_mode <= mode_code(overcurrent_absent,
                                overcurrent_per_port_select);
        end
    end

endmodule // usb_host_periodic_and_root_hub_config

// [usb_periodic_defs.vh]
`ifndef USB_PERIODIC_DEFS_VH
`define USB_PERIODIC_DEFS_VH

// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define OFF_PERIODIC_BEGIN 8'h40
`define OFF_SLOW_MARGIN 8'h44
`define OFF_RH_DESC_FIRST 8'h48
`define OFF_FRAME_INTERVAL 8'h50
`define OFF_SCHED_STATUS 8'h54

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define RST_PERIODIC_BEGIN 14'h0000
`define RST_SLOW_MARGIN 12'h000
`define RST_RH_DESC_FIRST 32'h01001102
`define RST_FRAME_INTERVAL 14'h2edf

// -------------------------------------------------------------
// field positions in the first root hub descriptor
// -------------------------------------------------------------
`define RH_SETTLE_HI 31
`define RH_SETTLE_LO 24
`define RH_OC_ABSENT 12
`define RH_OC_PER_PORT 11
`define RH_COMPOUND 10
`define RH_ALWAYS_ON 9
`define RH_GRANULARITY 8
`define RH_PORTS_HI 7
`define RH_PORTS_LO 0

// -------------------------------------------------------------
// widths and bit time
// -------------------------------------------------------------
`define FRAME_W 14
`define MARGIN_W 12
`define CLK_HZ 25'd20000000
`define BIT_HZ 25'd12000000
`define ACC_W 25

`endif

// [frame_countdown.v]
`include "usb_periodic_defs.vh"

// -------------------------------------------------------------
// frame bit-time countdown
// -------------------------------------------------------------
module frame_countdown (
    input wire ref_clk,
    input wire rst_b,
    input wire run,
    input wire [13:0] frame_interval,
    output reg [13:0] frame_bits_left,
    output reg bit_tick,
    output reg frame_start
);

    reg [24:0] phase;
    wire [24:0] next_phase_raw;

    // fractional accumulator makes 12 mhz bit ticks from a 20 mhz clock
    assign next_phase_raw = phase + `BIT_HZ;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= 25'h0000000;
            bit_tick <= 1'b0;
        end else if (!run) begin
            phase <= 25'h0000000;
            bit_tick <= 1'b0;
        end else if (next_phase_raw >= `CLK_HZ) begin
            phase <= next_phase_raw - `CLK_HZ;
            bit_tick <= 1'b1;
        end else begin
            phase <= next_phase_raw;
            bit_tick <= 1'b0;
        end
    end

    // decrement each bit time, reload from the interval at zero
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_bits_left <= 14'h0000;
            frame_start <= 1'b0;
        end else if (!run) begin
            frame_bits_left <= frame_interval; // loaded from the interval every cycle while stopped
            frame_start <= 1'b0;
        end else if (bit_tick) begin
            if (frame_bits_left == 14'h0000) begin
                frame_bits_left <= frame_interval;
                frame_start <= 1'b1;
            end else begin
                frame_bits_left <= frame_bits_left - 14'h0001;
                frame_start <= 1'b0;
            end
        end else begin
            frame_start <= 1'b0;
        end
    end

endmodule // frame_countdown

// [usb_cfg_monitor.sv]
// ----------------------------------------------------------
// port checker for the periodic and root hub config block
// ----------------------------------------------------------
module usb_cfg_monitor (
    input logic ref_clk,
    input logic rst_b,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic operational,
    input logic xact_busy,
    input logic ls_request,
    input logic [13:0] frame_bits_left,
    input logic periodic_priority,
    input logic ls_start
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    ready_after_setup_a:
        assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    ready_pulse_a:
        assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_in_access_a:
        assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_with_ready_a:
        assert property (pslverr |-> pready)
        else $error("error without ready");
    refused_read_zero_a:
        assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    compound_zero_a:
        assert property (pready && !pwrite && paddr == 8'h48 |-> !prdata[10])
        else $error("compound flag set");
    // registered copy lags, so look two cycles back for run state
    countdown_step_a:
        assert property (operational && $past(operational, 2)
            && $past(frame_bits_left) != 14'h0
            && frame_bits_left != $past(frame_bits_left)
            |-> frame_bits_left == $past(frame_bits_left) - 14'h1)
        else $error("countdown skipped");
    priority_idle_a:
        assert property ($rose(periodic_priority) |-> !$past(xact_busy))
        else $error("priority cut a transaction");
    grant_after_req_a:
        assert property (ls_start |-> $past(ls_request))
        else $error("grant without request");

    cover property (ls_start);
    cover property (periodic_priority);
    cover property (pready && pslverr);
endmodule // usb_cfg_monitor

bind usb_host_periodic_and_root_hub_config usb_cfg_monitor u_mon (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .operational(operational), .xact_busy(xact_busy),
    .ls_request(ls_request), .frame_bits_left(frame_bits_left),
    .periodic_priority(periodic_priority), .ls_start(ls_start));

// [xact_engine.sv]
// ----------------------------------------------------------
// list engine model: busy flag and low-speed requests
// ----------------------------------------------------------
module xact_engine (
    input logic ref_clk,
    input logic rst_b,
    input logic force_busy,
    input logic want_ls,
    input logic ls_start,
    output logic xact_busy,
    output logic ls_request
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] left;
    // a granted short packet keeps the engine busy for a spell
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 4'h0;
        end else if (ls_start && left == 4'h0) begin
            left <= 4'h8;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
    assign xact_busy = force_busy || left != 4'h0;
    assign ls_request = want_ls && left == 4'h0;
endmodule // xact_engine

// [usb_host_periodic_and_root_hub_config_tb.sv]
`include "usb_periodic_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    bad_count++; $display("Error %s expected %h seen %h", n, e, g); end end
// ----------------------------------------------------------
// testbench
// ----------------------------------------------------------
module usb_host_periodic_and_root_hub_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic operational = 0, force_busy = 0, want_ls = 0, er;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, w, dsc, seed = 32'h49122538;
    logic [3:0] pstrb = 0;
    wire [31:0] prdata;
    wire [13:0] frame_bits_left;
    wire [1:0] power_mode, overcurrent_mode;
    wire pready, pslverr, xact_busy, ls_request, periodic_priority;
    wire ls_start_ok, ls_start;
    int bad_count = 0, cmp_count = 0, i;

    usb_host_periodic_and_root_hub_config
        u_usb_host_periodic_and_root_hub_config (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .operational(operational), .xact_busy(xact_busy),
        .ls_request(ls_request), .frame_bits_left(frame_bits_left),
        .periodic_priority(periodic_priority), .ls_start_ok(ls_start_ok),
        .ls_start(ls_start), .power_mode(power_mode),
        .overcurrent_mode(overcurrent_mode));
    xact_engine u_xact_engine (.ref_clk(ref_clk), .rst_b(rst_b),
        .force_busy(force_busy), .want_ls(want_ls), .ls_start(ls_start),
        .xact_busy(xact_busy), .ls_request(ls_request));

    always #25 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // only settle time, the option bits and the fixed port count survive
    function automatic logic [31:0] exp_desc(input logic [31:0] v);
        return (v & 32'hff001b00) | 32'h00000002;
    endfunction
    function automatic logic [1:0] exp_mode(input logic off, input logic sel);
        return off ? 2'h2 : {1'b0, sel};
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input [7:0] a, input wr, input [31:0] d,
        input [3:0] s);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input [7:0] a, input [31:0] e);
        apb(a, 1'b0, 32'h0, 4'hf);
        `CHK("prdata", e, rd)
    endtask
    task automatic wait_left(input [13:0] v);
        int n;
        n = 0;
        while (frame_bits_left !== v && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 2000) bad_count++;
        repeat (3) @(posedge ref_clk);
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd_chk(`OFF_PERIODIC_BEGIN, 32'h0);
        rd_chk(`OFF_SLOW_MARGIN, 32'h0);
        rd_chk(`OFF_RH_DESC_FIRST, `RST_RH_DESC_FIRST);
        // descriptor writes first while stopped, then while running
        for (i = 0; i < 8; i++) begin
            operational <= i[2];
            dsc = xs();
            dsc[9:8] = i[1:0];
            dsc[12:11] = i[2:1];
            apb(`OFF_RH_DESC_FIRST, 1'b1, dsc, 4'hf);
            `CHK("pslverr", 1'b0, er)
            rd_chk(`OFF_RH_DESC_FIRST, exp_desc(dsc));
            `CHK("power", exp_mode(dsc[9], dsc[8]), power_mode)
            `CHK("oc", exp_mode(dsc[12], dsc[11]), overcurrent_mode)
            w = xs();
            apb(`OFF_PERIODIC_BEGIN, 1'b1, w, 4'hf);
            rd_chk(`OFF_PERIODIC_BEGIN, w & 32'h3fff);
            apb(`OFF_SLOW_MARGIN, 1'b1, w, 4'hf);
            rd_chk(`OFF_SLOW_MARGIN, w & 32'hfff);
        end
        apb(`OFF_RH_DESC_FIRST, 1'b1, 32'h0, 4'h7);
        `CHK("pslverr", 1'b1, er)
        rd_chk(`OFF_RH_DESC_FIRST, exp_desc(dsc));
        apb(8'h60, 1'b0, 32'h0, 4'hf);
        `CHK("pslverr", 1'b1, er)
        `CHK("prdata", 32'h0, rd)
        // short frame so thresholds come round quickly
        operational <= 1'b0;
        force_busy <= 1'b1;
        apb(`OFF_FRAME_INTERVAL, 1'b1, 32'd200, 4'hf);
        rd_chk(`OFF_FRAME_INTERVAL, 32'd200);
        apb(`OFF_PERIODIC_BEGIN, 1'b1, 32'd180, 4'hf);
        apb(`OFF_SLOW_MARGIN, 1'b1, 32'd150, 4'hf);
        operational <= 1'b1;
        wait_left(14'd120);
        `CHK("ls_ok", 1'b0, ls_start_ok)
        wait_left(14'd90);
        `CHK("prio", 1'b0, periodic_priority)
        force_busy <= 1'b0;
        repeat (3) @(posedge ref_clk);
        `CHK("prio", 1'b1, periodic_priority)
        apb(`OFF_SCHED_STATUS, 1'b0, 32'h0, 4'hf);
        `CHK("status", 32'h00020000, rd & 32'h00030000)
        wait_left(14'd190);
        `CHK("prio", 1'b0, periodic_priority)
        `CHK("ls_ok", 1'b1, ls_start_ok)
        want_ls <= 1'b1;
        repeat (4) @(posedge ref_clk);
        `CHK("busy", 1'b1, xact_busy)
        want_ls <= 1'b0;
        wait_left(14'd140);
        want_ls <= 1'b1;
        repeat (4) @(posedge ref_clk);
        `CHK("ls_start", 1'b0, ls_start)
        end_sim();
    end
endmodule // usb_host_periodic_and_root_hub_config_tb
